// >>> hdl/cp_ctrl_defines.svh
// Timing counts and thresholds for the charge pump control block.
`ifndef CP_CTRL_DEFINES_SVH
`define CP_CTRL_DEFINES_SVH
`define CLK_PERIOD_NS 4
`define SOFT_START_TIMEOUT_MS 100
`define SOFT_START_TIMEOUT_CYC ((`SOFT_START_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define COOLDOWN_SW_CYC 1024
`define WATCHDOG_CYC 64
`define SYNC_SEEN_EDGES 4
`define OSC_HALF_DIV 8
`define UV_PCT 80
`endif

// >>> hdl/cp_ctrl_pkg.sv
// Types shared by the charge pump control block.
package cp_ctrl_pkg;
    typedef enum logic [2:0] {
        ST_OFF, ST_WAIT_FAULT, ST_SOFT_START, ST_FULL_POWER, ST_COOLDOWN, ST_LATCHED
    } cp_state_t;

    typedef struct packed {
        logic over_temp;
        logic input_undervoltage_lockout;
        logic over_current;
        logic short_circuit;
    } fault_in_t;

    typedef struct packed {
        logic phase_a;
        logic phase_b;
        logic stage_on;
        logic soft_start;
    } stage_ctl_t;
endpackage : cp_ctrl_pkg

// >>> hdl/cp_ctrl.sv
// Clock selection, watchdog and protection state machine for the charge pump.
`timescale 1ns/100ps
`include "cp_ctrl_defines.svh"

// Overview of operation
// (R01) Strap low: internal oscillator, driven out
// (R02) Strap open: sync pin input, external clock
// (R03) Phase toggles at half selected clock
// (R04) Watchdog falls back on missing external clock
// (R05) Return to external clock when seen
// (R06) Host avoids external clock for single module
// (R07) Over-temperature: power-good low, auto restart
// (R08) Input undervoltage: hold off until clear, enabled
// (R09) Host keeps output unloaded during restart
// (R10) Overcurrent: cool down, retry repeatedly
// (R11) Short circuit latches off until enable toggles
// (R12) Soft-start timeout latches off until toggle
// (R13) External power-good pull-down forces soft-start
// (R14) Short pull-down returns to full power
// (R15) Long pull-down completes full soft-start
// (R16) Output undervoltage: off, cool down, soft-start
// (R17) Soft-start timeout nominally 100 ms
// (R18) Output undervoltage below 80 percent target
// (R19) Straps sampled once before stage enabled
// (R20) Cool-down counted in switching clock cycles
module cp_ctrl
    import cp_ctrl_pkg::*;
#(
    parameter int unsigned SS_TIMEOUT_CYC = `SOFT_START_TIMEOUT_CYC,
    parameter int unsigned COOLDOWN_CYC = `COOLDOWN_SW_CYC,
    parameter int unsigned WDOG_CYC = `WATCHDOG_CYC,
    parameter int unsigned LEVEL_W = 12
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic enable,
    input wire logic clock_source_strap,
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe_n,
    input wire fault_in_t faults,
    input wire logic [LEVEL_W-1:0] vin_level,
    input wire logic [LEVEL_W-1:0] vout_level,
    input wire logic power_good_line_in,
    output logic power_good_line_out,
    output logic power_good_line_oe_n,
    output stage_ctl_t stage,
    output logic ext_clock_active,
    output cp_state_t state
);
    localparam int CW = $clog2(SS_TIMEOUT_CYC + 1);

    // A flag stays at zero-target so a dead input never counts as reached.
    function automatic logic reached(input logic [LEVEL_W-1:0] vo, input logic [LEVEL_W-1:0] vi);
        reached = ({2'h0, vo} >= {2'h0, vi} >> 2) && (vi != '0);
    endfunction : reached

    function automatic logic under_pct(input logic [LEVEL_W-1:0] vo, input logic [LEVEL_W-1:0] vi);
        // Worked at 32 bits, since the products overflow any width near the level width.
        under_pct = (32'(vo) * 32'd4 * 32'd100) < (32'(vi) * 32'(`UV_PCT));
    endfunction : under_pct

    // Strap capture, oscillator, sync watchdog.
    logic strap_ext_q, strap_ext_d, strap_done_q, strap_done_d;
    logic [3:0] osc_cnt_q, osc_cnt_d;
    logic osc_q, osc_d;
    logic sync_s1_q, sync_s2_q, sync_s3_q;
    logic [$clog2(WDOG_CYC+1)-1:0] wd_q, wd_d;
    logic [2:0] seen_q, seen_d;
    logic ext_q, ext_d;
    logic sel_q, sel_d, sel_prev_q;
    logic sw_tick;
    logic sync_edge;

    always_comb begin
        strap_ext_d = strap_ext_q;
        strap_done_d = strap_done_q;
        // (R19) Sample once before enabling.
        if (!strap_done_q && enable) begin
            strap_ext_d = clock_source_strap;
            strap_done_d = 1'b1;
        end
        osc_cnt_d = osc_cnt_q + 4'h1;
        osc_d = osc_q;
        if (osc_cnt_q == 4'(`OSC_HALF_DIV - 1)) begin
            osc_cnt_d = 4'h0;
            osc_d = ~osc_q;
        end
        sync_edge = sync_s2_q & ~sync_s3_q;
        wd_d = wd_q;
        seen_d = seen_q;
        ext_d = ext_q;
        // (R04) Missing clock watchdog.
        if (sync_edge) begin
            wd_d = '0;
        end else if (wd_q != ($bits(wd_q))'(WDOG_CYC)) begin
            wd_d = wd_q + 1'b1;
        end else begin
            ext_d = 1'b0;
            seen_d = '0;
        end
        // (R05) Resume external after enough edges.
        if (sync_edge && !ext_q) begin
            if (seen_q == 3'(`SYNC_SEEN_EDGES - 1)) begin
                ext_d = 1'b1;
            end else begin
                seen_d = seen_q + 3'h1;
            end
        end
        if (!strap_ext_q) begin
            ext_d = 1'b0;
        end
        // (R02) External clock only in open-strap mode.
        sel_d = (strap_ext_q && ext_q) ? sync_s2_q : osc_q;
        sw_tick = sel_q & ~sel_prev_q;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_ext_q <= 1'b0;
            strap_done_q <= 1'b0;
            osc_cnt_q <= 4'h0;
            osc_q <= 1'b0;
            sync_s1_q <= 1'b0;
            sync_s2_q <= 1'b0;
            sync_s3_q <= 1'b0;
            wd_q <= '0;
            seen_q <= 3'h0;
            ext_q <= 1'b0;
            sel_q <= 1'b0;
            sel_prev_q <= 1'b0;
        end else begin
            strap_ext_q <= strap_ext_d;
            strap_done_q <= strap_done_d;
            osc_cnt_q <= osc_cnt_d;
            osc_q <= osc_d;
            sync_s1_q <= sync_in;
            sync_s2_q <= sync_s1_q;
            sync_s3_q <= sync_s2_q;
            wd_q <= wd_d;
            seen_q <= seen_d;
            ext_q <= ext_d;
            sel_q <= sel_d;
            sel_prev_q <= sel_q;
        end
    end

    // Protection state machine.
    cp_state_t st_q, st_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic phase_q, phase_d;
    logic en_prev_q;
    logic rearm;
    logic run;
    logic pg_ext_low;
    logic stage_on_q, stage_on_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        phase_d = phase_q;
        rearm = enable && !en_prev_q;
        pg_ext_low = !power_good_line_in;
        case (st_q)
            ST_OFF: begin
                if (enable && strap_done_q) begin
                    st_d = ST_WAIT_FAULT;
                end
            end
            // (R08) Hold off while undervoltage or overheated.
            ST_WAIT_FAULT: begin
                if (!faults.input_undervoltage_lockout && !faults.over_temp) begin
                    st_d = ST_SOFT_START;
                    cnt_d = '0;
                end
            end
            ST_SOFT_START: begin
                cnt_d = cnt_q + 1'b1;
                // (R12) (R17) Timeout latches off.
                // A held-low line with the target met is not a timeout, so it is gated here.
                if (cnt_q == CW'(SS_TIMEOUT_CYC - 1) && !reached(vout_level, vin_level)) begin
                    st_d = ST_LATCHED;
                // (R14) (R15) Exit once line released.
                end else if (reached(vout_level, vin_level) && !pg_ext_low) begin
                    st_d = ST_FULL_POWER;
                end
            end
            ST_FULL_POWER: begin
                // (R13) External pull-down restarts soft-start.
                if (pg_ext_low) begin
                    st_d = ST_SOFT_START;
                    cnt_d = '0;
                // (R16) (R18) Output undervoltage cools down.
                end else if (under_pct(vout_level, vin_level)) begin
                    st_d = ST_COOLDOWN;
                    cnt_d = '0;
                end
            end
            // (R20) Cool-down counts switching cycles.
            ST_COOLDOWN: begin
                if (sw_tick) begin
                    cnt_d = cnt_q + 1'b1;
                end
                if (cnt_q == CW'(COOLDOWN_CYC)) begin
                    st_d = ST_WAIT_FAULT;
                end
            end
            ST_LATCHED: begin
                if (rearm) begin
                    st_d = ST_WAIT_FAULT;
                end
            end
            default: st_d = ST_OFF;
        endcase
        // (R07) Over-temperature and undervoltage: persistent hold.
        if (st_q inside {ST_SOFT_START, ST_FULL_POWER} &&
            (faults.over_temp || faults.input_undervoltage_lockout)) begin
            st_d = ST_WAIT_FAULT;
        end
        // (R10) Overcurrent retries through cool-down.
        if (st_q inside {ST_SOFT_START, ST_FULL_POWER} && faults.over_current) begin
            st_d = ST_COOLDOWN;
            cnt_d = '0;
        end
        // (R11) Short circuit outranks all other faults; only enable low overrides it.
        if (st_q != ST_OFF && faults.short_circuit) begin
            st_d = ST_LATCHED;
        end
        if (!enable && st_q != ST_LATCHED) begin
            st_d = ST_OFF;
        end
        run = st_q inside {ST_SOFT_START, ST_FULL_POWER};
        stage_on_d = st_d inside {ST_SOFT_START, ST_FULL_POWER};
        // (R03) Phase toggles on each selected clock rise while in soft-start or full power.
        phase_d = (run && sw_tick) ? ~phase_q : phase_q;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_OFF;
            cnt_q <= '0;
            phase_q <= 1'b0;
            en_prev_q <= 1'b0;
            stage_on_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            phase_q <= phase_d;
            en_prev_q <= enable;
            stage_on_q <= stage_on_d;
        end
    end

    // (R01) Internal clock driven out when strapped low.
    assign sync_out = osc_q;
    assign sync_oe_n = strap_ext_q || !strap_done_q;
    // Power-good pulled low while enabled, except when off, at full power or at the soft-start target.
    assign power_good_line_out = 1'b0;
    // (R15) Release line at soft-start target.
    // The line is let go once the target is met, so a module still pulling it low keeps us here.
    assign power_good_line_oe_n = !(enable && st_q != ST_FULL_POWER && st_q != ST_OFF &&
        !(st_q == ST_SOFT_START && reached(vout_level, vin_level)));
    assign stage.phase_a = phase_q & stage_on_q;
    assign stage.phase_b = ~phase_q & stage_on_q;
    assign stage.stage_on = stage_on_q;
    assign stage.soft_start = (st_q == ST_SOFT_START);
    assign ext_clock_active = ext_q;
    assign state = st_q;

    // (R11) Short circuit latches.
    a_short_latch: assert property (@(posedge clk) disable iff (!reset_n)
        (st_q != ST_OFF && faults.short_circuit) |=> st_q == ST_LATCHED)
        else $error("short circuit did not latch");
    // (R12) Latched state holds without toggle.
    a_latch_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (st_q == ST_LATCHED && !rearm) |=> st_q == ST_LATCHED)
        else $error("latched state left without enable toggle");
    // (R13) Pull-down forces soft-start.
    a_pg_soft: assert property (@(posedge clk) disable iff (!reset_n)
        (st_q == ST_FULL_POWER && pg_ext_low && enable && !faults.short_circuit &&
         !faults.over_current && !faults.over_temp && !faults.input_undervoltage_lockout)
        |=> st_q == ST_SOFT_START)
        else $error("pull-down did not force soft-start");
    // (R10) Overcurrent cools down.
    a_oc_cool: assert property (@(posedge clk) disable iff (!reset_n)
        (run && faults.over_current && enable && !faults.short_circuit)
        |=> st_q == ST_COOLDOWN)
        else $error("overcurrent did not start cool-down");
    // (R07) Power-good low while faulted.
    a_pg_fault: assert property (@(posedge clk) disable iff (!reset_n)
        (st_q == ST_WAIT_FAULT && enable) |-> !power_good_line_oe_n)
        else $error("power-good released during fault hold");
    // (R04) Watchdog fallback.
    a_wd_fall: assert property (@(posedge clk) disable iff (!reset_n)
        (wd_q == ($bits(wd_q))'(WDOG_CYC) && !sync_edge) |=> !ext_q)
        else $error("watchdog did not fall back");
    // (R01) Pin driven in internal mode.
    a_sync_drive: assert property (@(posedge clk) disable iff (!reset_n)
        (strap_done_q && !strap_ext_q) |-> !sync_oe_n)
        else $error("sync pin not driven in internal mode");
    // (R19) Strap frozen after capture.
    a_strap_hold: assert property (@(posedge clk) disable iff (!reset_n)
        strap_done_q |=> $stable(strap_ext_q))
        else $error("strap changed after capture");
    // (R03) Phase stable without tick.
    a_phase_rate: assert property (@(posedge clk) disable iff (!reset_n)
        !sw_tick |=> $stable(phase_q))
        else $error("phase toggled without switching clock edge");
endmodule : cp_ctrl

// >>> bench/cp_host_model.sv
// System-side model: power-good pull-up, other module pull-down, sync pin source.
`timescale 1ns/100ps
module cp_host_model (
    input wire logic clk,
    input wire logic ext_clk_on,
    input wire logic pg_pull,
    input wire logic sync_out,
    input wire logic sync_oe_n,
    input wire logic power_good_line_out,
    input wire logic power_good_line_oe_n,
    output logic sync_in,
    output logic power_good_line_in
);
    logic [2:0] div_q = 3'h0;
    logic ext_q = 1'b0;

    always_ff @(posedge clk) begin
        div_q <= div_q + 3'h1;
        if (div_q == 3'h7) begin
            ext_q <= ~ext_q;
        end
    end

    // clock only when commanded.
    // The idle pin sits on its pull-down resistor, so a stopped clock reads low.
    assign sync_in = !sync_oe_n ? sync_out : (ext_clk_on & ext_q);

    assign power_good_line_in = (power_good_line_oe_n | power_good_line_out) & !pg_pull;
endmodule : cp_host_model

// >>> bench/tb_cp_ctrl.sv
// Self-checking bench for the charge pump control block.
`timescale 1ns/100ps
module tb_cp_ctrl;
    import cp_ctrl_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic enable = 1'b0;
    logic strap = 1'b0;
    logic ext_on = 1'b0;
    logic pg_pull = 1'b0;
    fault_in_t faults = '0;
    logic [11:0] vin = 12'h400;
    logic [11:0] vout = 12'h000;
    logic sync_in, sync_out, sync_oe_n, pg_in, pg_out, pg_oe_n, ext_act;
    stage_ctl_t stage;
    cp_state_t state;
    int miscompares = 0;
    int tests_run = 0;

    initial begin
        forever #2 clk = ~clk;
    end

    cp_ctrl #(.SS_TIMEOUT_CYC(200), .COOLDOWN_CYC(4)) i_cp_ctrl (
        .clk(clk), .reset_n(reset_n), .enable(enable), .clock_source_strap(strap),
        .sync_in(sync_in), .sync_out(sync_out), .sync_oe_n(sync_oe_n), .faults(faults),
        .vin_level(vin), .vout_level(vout), .power_good_line_in(pg_in),
        .power_good_line_out(pg_out), .power_good_line_oe_n(pg_oe_n), .stage(stage),
        .ext_clock_active(ext_act), .state(state));

    cp_host_model i_cp_host_model (
        .clk(clk), .ext_clk_on(ext_on), .pg_pull(pg_pull), .sync_out(sync_out),
        .sync_oe_n(sync_oe_n), .power_good_line_out(pg_out),
        .power_good_line_oe_n(pg_oe_n), .sync_in(sync_in), .power_good_line_in(pg_in));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // A wait that runs out of cycles is a mismatch and closes the run.
    task automatic wait_st(input cp_state_t s, input int n);
        for (int i = 0; i < n && state !== s; i++) begin
            @(posedge clk);
            #1;
        end
        chk("state", {1'b0, s}, {1'b0, state});
        if (state !== s) begin
            end_of_test();
        end
    endtask : wait_st

    task automatic wait_ext(input logic v, input int n);
        for (int i = 0; i < n && ext_act !== v; i++) begin
            @(posedge clk);
            #1;
        end
        chk("ext clock active", {3'h0, v}, {3'h0, ext_act});
        if (ext_act !== v) begin
            end_of_test();
        end
    endtask : wait_ext

    task automatic do_reset(input logic s);
        @(posedge clk);
        reset_n <= 1'b0;
        enable <= 1'b0;
        strap <= s;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("reset state", {1'b0, ST_OFF}, {1'b0, state});
        chk("reset pg", 4'h1, {3'h0, pg_oe_n});
    endtask : do_reset

    task automatic bring_up();
        @(posedge clk);
        vout <= 12'h000;
        enable <= 1'b1;
        wait_st(ST_SOFT_START, 8);
        chk("pg soft-start", 4'h0, {3'h0, pg_oe_n});
        chk("pg drive level", 4'h0, {3'h0, pg_out});
        chk("soft flag on", 4'h1, {3'h0, stage.soft_start});
        @(posedge clk);
        vout <= 12'h100;
        wait_st(ST_FULL_POWER, 8);
        repeat (2) @(posedge clk);
        #1;
        chk("pg full", 4'h1, {3'h0, pg_oe_n});
        chk("stage on", 4'h1, {3'h0, stage.stage_on});
        chk("soft flag off", 4'h0, {3'h0, stage.soft_start});
        chk("phase pair", 4'h1, {3'h0, stage.phase_a ^ stage.phase_b});
    endtask : bring_up

    task automatic s_internal();
        int rises;
        int flips;
        logic sync_prev;
        logic phase_prev;
        rises = 0;
        flips = 0;
        do_reset(1'b0);
        bring_up();
        chk("sync drive", 4'h0, {3'h0, sync_oe_n});
        sync_prev = sync_in;
        phase_prev = stage.phase_a;
        repeat (320) begin
            @(posedge clk);
            #1;
            rises += (sync_in && !sync_prev) ? 1 : 0;
            flips += (stage.phase_a !== phase_prev) ? 1 : 0;
            sync_prev = sync_in;
            phase_prev = stage.phase_a;
        end
        chk("phase rate", 4'h1, {3'h0, (rises - flips) inside {[-1:1]}});
    endtask : s_internal

    task automatic s_pg_low();
        @(posedge clk);
        pg_pull <= 1'b1;
        wait_st(ST_SOFT_START, 8);
        repeat (3) @(posedge clk);
        #1;
        chk("pulled state", {1'b0, ST_SOFT_START}, {1'b0, state});
        @(posedge clk);
        pg_pull <= 1'b0;
        wait_st(ST_FULL_POWER, 8);
    endtask : s_pg_low

    task automatic s_retry();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            faults.over_current <= (k == 0);
            vout <= (k == 0) ? 12'h100 : 12'h0cc;
            wait_st(ST_COOLDOWN, 8);
            chk("pg cooldown", 4'h0, {3'h0, pg_oe_n});
            @(posedge clk);
            faults <= '0;
            vout <= 12'h100;
            wait_st(ST_FULL_POWER, 120);
        end
    endtask : s_retry

    task automatic s_hold();
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            faults <= (k == 0) ? 4'h8 : 4'h4;
            wait_st(ST_WAIT_FAULT, 8);
            repeat (20) @(posedge clk);
            #1;
            chk("hold", {1'b0, ST_WAIT_FAULT}, {1'b0, state});
            chk("pg hold", 4'h0, {3'h0, pg_oe_n});
            @(posedge clk);
            faults <= '0;
            wait_st(ST_FULL_POWER, 20);
        end
    endtask : s_hold

    task automatic s_latch(input logic timeout);
        @(posedge clk);
        enable <= !timeout;
        faults.short_circuit <= !timeout;
        repeat (2) @(posedge clk);
        enable <= 1'b1;
        vout <= 12'h000;
        wait_st(ST_LATCHED, timeout ? 260 : 4);
        @(posedge clk);
        faults <= '0;
        vout <= 12'h100;
        repeat (10) @(posedge clk);
        #1;
        chk("latched", {1'b0, ST_LATCHED}, {1'b0, state});
        @(posedge clk);
        enable <= 1'b0;
        repeat (2) @(posedge clk);
        enable <= 1'b1;
        wait_st(ST_FULL_POWER, 20);
    endtask : s_latch

    task automatic s_external();
        do_reset(1'b1);
        @(posedge clk);
        ext_on <= 1'b1;
        enable <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk("sync input", 4'h1, {3'h0, sync_oe_n});
        wait_ext(1'b1, 200);
        @(posedge clk);
        ext_on <= 1'b0;
        wait_ext(1'b0, 150);
        @(posedge clk);
        ext_on <= 1'b1;
        wait_ext(1'b1, 150);
    endtask : s_external

    initial begin
        s_internal();
        s_pg_low();
        s_retry();
        s_hold();
        s_latch(1'b0);
        s_latch(1'b1);
        s_external();
        end_of_test();
    end
endmodule : tb_cp_ctrl
